// file: hw/ecfm_defs.svh
`ifndef ECFM_DEFS_SVH
`define ECFM_DEFS_SVH

// number of qualified faults: thirteen engine faults, red lamp, bus-off
`define ECFM_NF 15

// register byte offsets
`define ECFM_OFF_ENG_TYPE 8'h00
`define ECFM_OFF_SUPPRESS 8'h04
`define ECFM_OFF_BOFF_CFG 8'h08
`define ECFM_OFF_ACTIVE 8'h0c
`define ECFM_OFF_CLASS 8'h10
`define ECFM_OFF_IRQ_STS 8'h14
`define ECFM_OFF_IRQ_MASK 8'h18
`define ECFM_OFF_LAST_EVT 8'h1c
`define ECFM_OFF_RAW 8'h20
`define ECFM_OFF_STATUS 8'h24

// reset values
`define ECFM_RST_ENG_TYPE 8'h00
`define ECFM_RST_SUPPRESS 16'h0000
`define ECFM_RST_BOFF_CFG 2'h1
`define ECFM_RST_IRQ_MASK 15'h0000

// bus-off action encoding
`define ECFM_BOFF_OFF 2'h0
`define ECFM_BOFF_WARN 2'h1

// suppression mask bit positions
`define ECFM_MB_OIL_P_LOW 0
`define ECFM_MB_OIL_P_MIN 1
`define ECFM_MB_OIL_T_HIGH 2
`define ECFM_MB_OIL_T_MAX 3
`define ECFM_MB_COOL_T_HIGH 4
`define ECFM_MB_COOL_T_MAX 5
`define ECFM_MB_COOL_L_LOW 6
`define ECFM_MB_COOL_L_MIN 7
`define ECFM_MB_WATER_FUEL 8
`define ECFM_MB_BATT_LOW 9
`define ECFM_MB_OVERSPEED 10
`define ECFM_MB_ALTERNATOR 11
`define ECFM_MB_RED_CLASS 13
`define ECFM_MB_YELLOW 14
`define ECFM_MB_RED 15

// fault codes
`define ECFM_CODE_ALTERNATOR 8'h69
`define ECFM_CODE_OVERSPEED 8'h76
`define ECFM_CODE_COOL_T_HIGH 8'h84
`define ECFM_CODE_COOL_T_MAX 8'h86
`define ECFM_CODE_COOL_L_MIN 8'h87
`define ECFM_CODE_COOL_L_LOW 8'h88
`define ECFM_CODE_BATT_LOW 8'h89
`define ECFM_CODE_OIL_P_MIN 8'h8e
`define ECFM_CODE_OIL_P_LOW 8'h90
`define ECFM_CODE_OIL_T_HIGH 8'h9e
`define ECFM_CODE_OIL_T_MAX 8'h9f
`define ECFM_CODE_WATER_FUEL 8'ha0
`define ECFM_CODE_YELLOW 8'hc6
`define ECFM_CODE_RED 8'hc7
`define ECFM_CODE_BUS_OFF 8'h3e

`endif

// file: hw/ecfm_pkg.sv
package ecfm_pkg;

	typedef enum logic [2:0] {
		ECFM_MODE_OFF = 3'b000,
		ECFM_MODE_MANUAL = 3'b001,
		ECFM_MODE_AUTO = 3'b010,
		ECFM_MODE_TEST = 3'b011,
		ECFM_MODE_REMOTE = 3'b100
	} ecfm_mode_e;

	typedef struct packed {
		logic active;
		logic alarm;
		logic rise;
	} ecfm_qual_s;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [7:0] eng_type;
		logic [15:0] supp;
		logic [1:0] boff_cfg;
		logic [14:0] irq_sts;
		logic [14:0] irq_msk;
		logic irq;
		logic [7:0] evt_code;
		logic evt_alarm;
		logic evt_valid;
		logic [15:0] evt_cnt;
		logic any_warn;
		logic any_alarm;
	} ecfm_top_s;

endpackage : ecfm_pkg

// file: hw/ecfm_qual.sv
`timescale 1ns/1ps
`default_nettype none

module ecfm_qual (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic arm_i,
	input wire logic raw_i,
	input wire logic supp_i,
	input wire logic alarm_i,
	output logic active_o,
	output logic alarm_o,
	output logic rise_o
);

	ecfm_pkg::ecfm_qual_s st_ff;
	ecfm_pkg::ecfm_qual_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.active = arm_i & raw_i & ~supp_i;
		// class reads zero while the fault is idle
		nxt_st.alarm = nxt_st.active & alarm_i;
		nxt_st.rise = nxt_st.active & ~st_ff.active;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign active_o = st_ff.active;
	assign alarm_o = st_ff.alarm;
	assign rise_o = st_ff.rise;

endmodule : ecfm_qual

`default_nettype wire

// file: hw/ecfm_top.sv
// Function
// - faults armed only while engine type register is nonzero
// - faults armed only in manual, automatic, test, remote-start modes
// - alternator failure raises warning 105 unless mask bit 11 set
// - overspeed raises alarm 118 unless mask bit 10 set
// - high coolant temperature raises warning 132 unless mask bit 4 set
// - maximum coolant temperature raises alarm 134 unless mask bit 5 set
// - minimum coolant level raises alarm 135 unless mask bit 7 set
// - low coolant level raises warning 136 unless mask bit 6 set
// - low battery voltage raises warning 137 unless mask bit 9 set
// - minimum oil pressure raises alarm 142 unless mask bit 1 set
// - low oil pressure raises warning 144 unless mask bit 0 set
// - high oil temperature raises warning 158 unless mask bit 2 set
// - maximum oil temperature raises alarm 159 unless mask bit 3 set
// - water in fuel raises warning 160 unless mask bit 8 set
// - yellow lamp raises warning 198 unless mask bit 14 set
// - red lamp raises fault 199, alarm by default, unless bit 15 set
// - mask bit 13 selects warning or alarm class for red lamp
// - controller bus-off raises configurable fault when engine type nonzero
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ecfm_defs.svh"

module ecfm_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [2:0] mode_i,
	input wire logic [13:0] can_fault_i,
	input wire logic bus_off_i,
	output logic [14:0] fault_active_o,
	output logic [14:0] fault_alarm_o,
	output logic warning_o,
	output logic alarm_o,
	output logic [7:0] event_code_o,
	output logic event_alarm_o,
	output logic event_valid_o,
	output logic irq_o
);

	ecfm_pkg::ecfm_top_s st_ff;
	ecfm_pkg::ecfm_top_s nxt_st;

	logic [14:0] raw;
	logic [14:0] act;
	logic [14:0] cls;
	logic [14:0] rise;
	logic [14:0] supp_vec;
	logic [14:0] alarm_vec;
	logic armed;
	logic mode_ok;
	logic acc;
	logic [7:0] adr;

	// per-fault suppression; bus-off is gated by its action field instead
	function automatic logic fault_supp(input int idx, input logic [15:0] m,
		input logic [1:0] bcfg);
		logic r;
		r = 1'b0;
		case (idx)
			0: r = m[`ECFM_MB_ALTERNATOR];
			1: r = m[`ECFM_MB_OVERSPEED];
			2: r = m[`ECFM_MB_COOL_T_HIGH];
			3: r = m[`ECFM_MB_COOL_T_MAX];
			4: r = m[`ECFM_MB_COOL_L_MIN];
			5: r = m[`ECFM_MB_COOL_L_LOW];
			6: r = m[`ECFM_MB_BATT_LOW];
			7: r = m[`ECFM_MB_OIL_P_MIN];
			8: r = m[`ECFM_MB_OIL_P_LOW];
			9: r = m[`ECFM_MB_OIL_T_HIGH];
			10: r = m[`ECFM_MB_OIL_T_MAX];
			11: r = m[`ECFM_MB_WATER_FUEL];
			12: r = m[`ECFM_MB_YELLOW];
			13: r = m[`ECFM_MB_RED];
			14: r = (bcfg == `ECFM_BOFF_OFF);
			default: r = 1'b1;
		endcase
		return r;
	endfunction : fault_supp

	// class of each fault: 1 is alarm, 0 is warning
	function automatic logic fault_alarm(input int idx, input logic [15:0] m,
		input logic [1:0] bcfg);
		logic r;
		r = 1'b0;
		case (idx)
			1: r = 1'b1;
			3: r = 1'b1;
			4: r = 1'b1;
			7: r = 1'b1;
			10: r = 1'b1;
			13: r = ~m[`ECFM_MB_RED_CLASS];
			// unload and block actions both count as alarm class
			14: r = (bcfg != `ECFM_BOFF_WARN);
			default: r = 1'b0;
		endcase
		return r;
	endfunction : fault_alarm

	function automatic logic [7:0] fault_code(input int idx);
		logic [7:0] r;
		r = 8'h00;
		case (idx)
			0: r = `ECFM_CODE_ALTERNATOR;
			1: r = `ECFM_CODE_OVERSPEED;
			2: r = `ECFM_CODE_COOL_T_HIGH;
			3: r = `ECFM_CODE_COOL_T_MAX;
			4: r = `ECFM_CODE_COOL_L_MIN;
			5: r = `ECFM_CODE_COOL_L_LOW;
			6: r = `ECFM_CODE_BATT_LOW;
			7: r = `ECFM_CODE_OIL_P_MIN;
			8: r = `ECFM_CODE_OIL_P_LOW;
			9: r = `ECFM_CODE_OIL_T_HIGH;
			10: r = `ECFM_CODE_OIL_T_MAX;
			11: r = `ECFM_CODE_WATER_FUEL;
			12: r = `ECFM_CODE_YELLOW;
			13: r = `ECFM_CODE_RED;
			14: r = `ECFM_CODE_BUS_OFF;
			default: r = 8'h00;
		endcase
		return r;
	endfunction : fault_code

	// byte-lane merge of a write onto an old register value
	function automatic logic [31:0] wr_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction : wr_merge

	assign raw = {bus_off_i, can_fault_i};
	assign adr = {wb_adr_i[7:2], 2'b00};
	// ack drops for one cycle between accesses, so no double action
	assign acc = wb_cyc_i & wb_stb_i & ~st_ff.ack;

	always_comb begin
		case (mode_i)
			ecfm_pkg::ECFM_MODE_MANUAL: mode_ok = 1'b1;
			ecfm_pkg::ECFM_MODE_AUTO: mode_ok = 1'b1;
			ecfm_pkg::ECFM_MODE_TEST: mode_ok = 1'b1;
			ecfm_pkg::ECFM_MODE_REMOTE: mode_ok = 1'b1;
			default: mode_ok = 1'b0;
		endcase
	end

	// bus-off shares the same arming, it only matters with an engine on can
	assign armed = (st_ff.eng_type != 8'h00) & mode_ok;

	for (genvar g = 0; g < `ECFM_NF; g++) begin : g_fault
		assign supp_vec[g] = fault_supp(g, st_ff.supp, st_ff.boff_cfg);
		assign alarm_vec[g] = fault_alarm(g, st_ff.supp, st_ff.boff_cfg);
		ecfm_qual u_qual (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.arm_i(armed),
			.raw_i(raw[g]),
			.supp_i(supp_vec[g]),
			.alarm_i(alarm_vec[g]),
			.active_o(act[g]),
			.alarm_o(cls[g]),
			.rise_o(rise[g])
		);
	end

	always_comb begin
		logic [31:0] m;
		logic [14:0] w1c;
		m = 32'h0;
		w1c = 15'h0000;
		nxt_st = st_ff;
		nxt_st.ack = acc;
		nxt_st.rdata = 32'h0;
		nxt_st.evt_valid = 1'b0;

		if (acc) begin
			if (adr == `ECFM_OFF_ENG_TYPE) begin
				m = wr_merge({24'h0, st_ff.eng_type}, wb_dat_i, wb_sel_i);
				nxt_st.rdata = {24'h0, st_ff.eng_type};
				if (wb_we_i) begin
					nxt_st.eng_type = m[7:0];
				end
			end else if (adr == `ECFM_OFF_SUPPRESS) begin
				m = wr_merge({16'h0, st_ff.supp}, wb_dat_i, wb_sel_i);
				nxt_st.rdata = {16'h0, st_ff.supp};
				if (wb_we_i) begin
					nxt_st.supp = m[15:0];
				end
			end else if (adr == `ECFM_OFF_BOFF_CFG) begin
				m = wr_merge({30'h0, st_ff.boff_cfg}, wb_dat_i, wb_sel_i);
				nxt_st.rdata = {30'h0, st_ff.boff_cfg};
				if (wb_we_i) begin
					nxt_st.boff_cfg = m[1:0];
				end
			end else if (adr == `ECFM_OFF_ACTIVE) begin
				nxt_st.rdata = {17'h0, act};
			end else if (adr == `ECFM_OFF_CLASS) begin
				nxt_st.rdata = {17'h0, cls};
			end else if (adr == `ECFM_OFF_IRQ_STS) begin
				m = wr_merge(32'h0, wb_dat_i, wb_sel_i);
				nxt_st.rdata = {17'h0, st_ff.irq_sts};
				if (wb_we_i) begin
					w1c = m[14:0];
				end
			end else if (adr == `ECFM_OFF_IRQ_MASK) begin
				m = wr_merge({17'h0, st_ff.irq_msk}, wb_dat_i, wb_sel_i);
				nxt_st.rdata = {17'h0, st_ff.irq_msk};
				if (wb_we_i) begin
					nxt_st.irq_msk = m[14:0];
				end
			end else if (adr == `ECFM_OFF_LAST_EVT) begin
				nxt_st.rdata = {st_ff.evt_cnt, 7'h00, st_ff.evt_alarm,
					st_ff.evt_code};
				// any write clears the event counter
				if (wb_we_i) begin
					nxt_st.evt_cnt = 16'h0000;
				end
			end else if (adr == `ECFM_OFF_RAW) begin
				nxt_st.rdata = {17'h0, raw};
			end else if (adr == `ECFM_OFF_STATUS) begin
				nxt_st.rdata = {28'h0, mode_i, armed};
			end else begin
				// unmapped: acked, reads zero, writes dropped
				nxt_st.rdata = 32'h0;
			end
		end

		// set wins over a clear in the same cycle
		nxt_st.irq_sts = (st_ff.irq_sts & ~w1c) | rise;

		// lowest fault index wins when several rise together
		for (int i = `ECFM_NF - 1; i >= 0; i--) begin
			if (rise[i]) begin
				nxt_st.evt_code = fault_code(i);
				nxt_st.evt_alarm = cls[i];
				nxt_st.evt_valid = 1'b1;
			end
		end
		// counts cycles with at least one new fault, saturating
		if ((|rise) && (nxt_st.evt_cnt != 16'hffff)) begin
			nxt_st.evt_cnt = nxt_st.evt_cnt + 16'h0001;
		end

		nxt_st.irq = |(nxt_st.irq_sts & nxt_st.irq_msk);
		nxt_st.any_warn = |(act & ~cls);
		nxt_st.any_alarm = |(act & cls);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
			st_ff.eng_type <= `ECFM_RST_ENG_TYPE;
			st_ff.supp <= `ECFM_RST_SUPPRESS;
			st_ff.boff_cfg <= `ECFM_RST_BOFF_CFG;
			st_ff.irq_msk <= `ECFM_RST_IRQ_MASK;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign wb_ack_o = st_ff.ack;
	assign wb_dat_o = st_ff.rdata;
	assign fault_active_o = act;
	assign fault_alarm_o = cls;
	assign warning_o = st_ff.any_warn;
	assign alarm_o = st_ff.any_alarm;
	assign event_code_o = st_ff.evt_code;
	assign event_alarm_o = st_ff.evt_alarm;
	assign event_valid_o = st_ff.evt_valid;
	assign irq_o = st_ff.irq;

endmodule : ecfm_top

`default_nettype wire

// file: test/ecfm_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ecfm_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [2:0] mode_i,
	input wire logic [13:0] can_fault_i,
	input wire logic bus_off_i,
	input wire logic [14:0] fault_active_o,
	input wire logic [14:0] fault_alarm_o,
	input wire logic warning_o,
	input wire logic alarm_o,
	input wire logic [7:0] event_code_o,
	input wire logic event_alarm_o,
	input wire logic event_valid_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_mode_disarm: assert property ((mode_i == 3'h0 || mode_i > 3'h4) |=> !fault_active_o)
		else $error("fault active while disarmed");
	a_warn_class: assert property ((fault_alarm_o & 15'h1b65) == 15'h0)
		else $error("warning fault shown as alarm");
	a_alarm_class: assert property ((fault_alarm_o & 15'h049a) == (fault_active_o & 15'h049a))
		else $error("alarm fault shown as warning");
	a_class_idle: assert property ((fault_alarm_o & ~fault_active_o) == 15'h0)
		else $error("class set on idle fault");
	a_raw_follow: assert property ((fault_active_o & ~$past({bus_off_i, can_fault_i})) == 15'h0)
		else $error("fault active without raw cause");
	a_warn_sum: assert property (warning_o == |$past(fault_active_o & ~fault_alarm_o))
		else $error("warning summary wrong");
	a_alarm_sum: assert property (alarm_o == |$past(fault_active_o & fault_alarm_o))
		else $error("alarm summary wrong");
	a_event_pulse: assert property (event_valid_o == |($past(fault_active_o) & ~$past(fault_active_o, 2)))
		else $error("event pulse not tied to a rise");
	// index 0 is lowest, so its rise always wins the event
	a_event_first: assert property ($past(fault_active_o[0]) && !$past(fault_active_o[0], 2)
		|-> event_code_o == 8'h69 && !event_alarm_o)
		else $error("alternator event code wrong");
endmodule : ecfm_sva
bind ecfm_top ecfm_sva u_sva (.clk_i, .rst_i, .mode_i, .can_fault_i, .bus_off_i, .fault_active_o,
	.fault_alarm_o, .warning_o, .alarm_o, .event_code_o, .event_alarm_o, .event_valid_o);
`default_nettype wire

// file: test/ecfm_ecu_model.sv
`timescale 1ns/1ps
`default_nettype none
module ecfm_ecu_model (
	input wire logic clk_i,
	output logic [13:0] fault_o
);
	initial fault_o = 14'h0;
	// lag models a slow engine unit reporting a few frames late
	task automatic report(input int i, input logic v, input int lag);
		repeat (lag) @(posedge clk_i);
		@(posedge clk_i);
		fault_o[i] <= v;
	endtask : report
endmodule : ecfm_ecu_model
`default_nettype wire

// file: test/ecfm_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ecfm_top_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, bus_off_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
	logic [31:0] s = 32'h00012629;
	logic [2:0] mode_i = 3'h1;
	logic [13:0] can_fault_i;
	logic [14:0] fault_active_o, fault_alarm_o;
	logic [7:0] event_code_o;
	logic wb_ack_o, warning_o, alarm_o, event_alarm_o, event_valid_o, irq_o;
	logic [31:0] qr[$], qe[$];
	int num_errors = 0, compares = 0;
	logic [0:13][7:0] cd = {8'h69, 8'h76, 8'h84, 8'h86, 8'h87, 8'h88, 8'h89,
		8'h8e, 8'h90, 8'h9e, 8'h9f, 8'ha0, 8'hc6, 8'hc7};
	logic [0:13][3:0] mb = {4'hb, 4'ha, 4'h4, 4'h5, 4'h7, 4'h6, 4'h9,
		4'h1, 4'h0, 4'h2, 4'h3, 4'h8, 4'he, 4'hf};
	logic [13:0] al = 14'h249a;
	logic [2:0] md;
	always #50 clk_i = ~clk_i;
	ecfm_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .mode_i, .can_fault_i, .bus_off_i, .fault_active_o,
		.fault_alarm_o, .warning_o, .alarm_o, .event_code_o, .event_alarm_o, .event_valid_o,
		.irq_o);
	ecfm_ecu_model ecu (.clk_i, .fault_o(can_fault_i));
	function automatic logic [31:0] xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// no local limit: only the watchdog ends a wait for ack
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		qr.push_back(e);
		wb(a, 1'b0, 32'h0);
	endtask : rd
	task end_sim;
		$display("comparisons %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	// oldest note answers each read ack and each event pulse
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			chk(wb_dat_o, qr.size() ? qr.pop_front() : 32'hbad);
		if (event_valid_o === 1'b1)
			chk({event_alarm_o, event_code_o}, qe.size() ? qe.pop_front() : 32'hbad);
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		num_errors++;
		end_sim;
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h1);
		rd(8'h30, 32'h0);
		ecu.report(1, 1'b1, 0);
		repeat (3) @(posedge clk_i);
		rd(8'h0c, 32'h0);
		ecu.report(1, 1'b0, 0);
		wb(8'h00, 1'b1, 32'h5);
		$display("reset and disarm test done");
		for (int i = 0; i < 14; i++) begin
			qe.push_back({al[i], cd[i]});
			ecu.report(i, 1'b1, i % 3);
			repeat (2) @(posedge clk_i);
			rd(8'h0c, 32'h1 << i);
			rd(8'h10, al[i] ? 32'h1 << i : 32'h0);
			wb(8'h04, 1'b1, 32'h1 << mb[i]);
			rd(8'h0c, 32'h0);
			ecu.report(i, 1'b0, 0);
			wb(8'h04, 1'b1, 32'h0);
		end
		chk(irq_o, 1'b0);
		$display("fault table test done");
		wb(8'h04, 1'b1, 32'h2000);
		qe.push_back(32'h0c7);
		ecu.report(13, 1'b1, 0);
		repeat (2) @(posedge clk_i);
		rd(8'h10, 32'h0);
		ecu.report(13, 1'b0, 0);
		wb(8'h04, 1'b1, 32'h0);
		qe.push_back(32'h03e);
		bus_off_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(8'h0c, 32'h4000);
		bus_off_i <= 1'b0;
		wb(8'h08, 1'b1, 32'h2);
		qe.push_back(32'h13e);
		bus_off_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(8'h10, 32'h4000);
		bus_off_i <= 1'b0;
		wb(8'h08, 1'b1, 32'h0);
		bus_off_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(8'h0c, 32'h0);
		bus_off_i <= 1'b0;
		$display("class and bus-off test done");
		wb(8'h14, 1'b1, 32'h7fff);
		wb(8'h18, 1'b1, 32'h2);
		qe.push_back(32'h176);
		ecu.report(1, 1'b1, 0);
		repeat (4) @(posedge clk_i);
		chk(irq_o, 1'b1);
		wb(8'h14, 1'b1, 32'h2);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b0);
		ecu.report(1, 1'b0, 0);
		// eighteen rise cycles so far, the last one overspeed as alarm
		rd(8'h1c, 32'h00120176);
		wb(8'h1c, 1'b1, 32'h0);
		rd(8'h1c, 32'h00000176);
		$display("interrupt test done");
		for (int k = 0; k < 16; k++) begin
			@(posedge clk_i);
			r = xs();
			// first pass walks every mode code, second pass is random
			md = (k < 8) ? k[2:0] : r[2:0];
			mode_i <= md;
			if (md inside {[3'h1:3'h4]}) qe.push_back(32'h090);
			ecu.report(8, 1'b1, 0);
			repeat (2) @(posedge clk_i);
			rd(8'h0c, md inside {[3'h1:3'h4]} ? 32'h100 : 32'h0);
			ecu.report(8, 1'b0, 0);
			repeat (2) @(posedge clk_i);
		end
		chk(qe.size(), 32'h0);
		$display("mode test done");
		end_sim;
	end
endmodule : ecfm_top_bench
`default_nettype wire
